// ---- bcp_cfg.svh ----
`ifndef BCP_CFG_SVH
`define BCP_CFG_SVH
// Function
// - decode frequency straps into crystal/clock choice
// - pll multiplier follows selected input frequency
// - boot straps pick usb or flash boot
// - failed flash load falls back to usb
// - hard reset pin tristates every io
// - boot loader runs after hard reset
// - normal mode runs cpu clock and plls
// - four low-power states are provided
// - suspend with phy on keeps only u3 phy clocked; suspend with phy off stops it too
// - io pins hold state in suspend
// - firmware or mailbox write enters suspend
// - dp, dm, id, resume wake suspend with phy on; id, vbus wake suspend with phy off
// - non-reset suspend wake keeps program counter
// - standby wake restarts cpu, resets counter
// - vbus, control line zero, reset leave standby

// register byte offsets
`define BCP_ADDR_CTRL 8'h00
`define BCP_ADDR_STATUS 8'h04
`define BCP_ADDR_INT_STAT 8'h08
`define BCP_ADDR_INT_MASK 8'h0C
// control register bits, write one to request
`define BCP_CTRL_SUSP_ON 0
`define BCP_CTRL_SUSP_OFF 1
`define BCP_CTRL_STANDBY 2
`define BCP_CTRL_PDOWN 3
// interrupt status bits
`define BCP_INT_BOOT_DONE 0
`define BCP_INT_FALLBACK 1
`define BCP_INT_WAKE 2
`define BCP_INT_STRAP_ERR 3
`define BCP_INT_W 4
`define BCP_INT_MASK_RST 4'h0
// wake source bit positions and edge kind (1 = any change)
`define BCP_WAKE_W 6
`define BCP_WK_DP 0
`define BCP_WK_DM 1
`define BCP_WK_ID 2
`define BCP_WK_SUPERSPEED_RECEIVE_PAIR 3
`define BCP_WK_VBUS 4
`define BCP_WK_CTL0 5
`define BCP_WAKE_ANY_CHANGE 6'h07
`define BCP_WAKE_L1_SRC 6'h0F
`define BCP_WAKE_L2_SRC 6'h14
`define BCP_WAKE_L3_SRC 6'h30
// pll multiplier per reference choice
`define BCP_PLL_MULT_19M2 8'h14
`define BCP_PLL_MULT_26M 8'h0F
`define BCP_PLL_MULT_38M4 8'h0A
`define BCP_PLL_MULT_52M 8'h08
// timing
`define BCP_CLK_MHZ 100
`define BCP_POR_TIME_US 1000
`endif

// ---- bcp_ctrl.sv ----
`timescale 1ns/1ps
`include "bcp_cfg.svh"
module bcp_ctrl import bcp_pkg::*; #(
  parameter int POR_CYCLES = `BCP_POR_TIME_US * `BCP_CLK_MHZ
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic hard_resetn_pin_in,
  input wire logic [2:0] ref_freq_select_straps_in,
  input wire logic [2:0] boot_source_straps_in,
  input wire logic [2:0] boot_source_float_in,
  input wire logic loader_done_in,
  input wire logic loader_fail_in,
  input wire logic fw_suspend_req_in,
  input wire logic dp_in,
  input wire logic dm_in,
  input wire logic id_detect_pin_in,
  input wire logic superspeed_receive_pair_resume_in,
  input wire logic vbus_detect_in,
  input wire logic parallel_control_line_zero_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic irq_out,
  output logic [2:0] ref_sel_out,
  output logic ref_is_crystal_out,
  output logic [7:0] pll_mult_out,
  output logic [1:0] boot_source_out,
  output logic boot_loader_run_out,
  output logic io_tristate_out,
  output logic io_hold_out,
  output logic cpu_clk_en_out,
  output logic pll_en_out,
  output logic osc_en_out,
  output logic phy_en_out,
  output logic phy_u3_out,
  output logic cpu_pc_reset_out,
  output logic [6:0] power_state_out
);
  localparam int POR_W = $clog2(POR_CYCLES + 1);
  localparam int WW = `BCP_WAKE_W;

  logic rst_meta;
  logic rst_n;
  logic hard_pin_n;
  logic [2:0] fsel_s;
  logic [2:0] boot_lvl_s;
  logic [2:0] boot_flt_s;
  logic [WW-1:0] wake_lvl_s;
  logic [POR_W-1:0] por_cnt;
  logic por_done;
  bcp_pstate_t state;
  bcp_pstate_t next_state;
  bcp_boot_src_t boot_src;
  logic strap_bad;
  logic [WW-1:0] wake_arm;
  logic [WW-1:0] wake_pend;
  logic wake_ack;
  logic any_wake;
  logic [`BCP_INT_W-1:0] int_stat;
  logic [`BCP_INT_W-1:0] int_mask;
  logic [`BCP_INT_W-1:0] int_set;
  logic ctrl_wr;
  logic int_rd;
  logic fallback_ev;

  // reset released through two flops
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // pins from outside the clock domain
  bcp_sync #(.WIDTH(9 + WW + 1)) u_pin_sync (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_n),
    .async_in({hard_resetn_pin_in, ref_freq_select_straps_in,
               boot_source_straps_in, boot_source_float_in,
               parallel_control_line_zero_in, vbus_detect_in,
               superspeed_receive_pair_resume_in, id_detect_pin_in,
               dm_in, dp_in}),
    .sync_out({hard_pin_n, fsel_s, boot_lvl_s, boot_flt_s, wake_lvl_s})
  );

  // power-on hold; the far side must keep power stable this long
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      por_cnt <= '0;
    end else if (!por_done) begin
      por_cnt <= por_cnt + POR_W'(1);
    end
  end
  assign por_done = (por_cnt == POR_W'(POR_CYCLES));

  // wake sources armed only in the states that they may end
  always_comb begin
    wake_arm = '0;
    if (state == BCP_ST_SUSP_ON) begin
      wake_arm = `BCP_WAKE_L1_SRC;
    end else if (state == BCP_ST_SUSP_OFF) begin
      wake_arm = `BCP_WAKE_L2_SRC;
    end else if (state == BCP_ST_STBY) begin
      wake_arm = `BCP_WAKE_L3_SRC;
    end
  end

  bcp_wake_latch #(.WIDTH(WW), .ANY_CHANGE(`BCP_WAKE_ANY_CHANGE)) u_wake (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_n),
    .level_in(wake_lvl_s),
    .arm_in(wake_arm),
    .ack_in(wake_ack),
    .pend_out(wake_pend)
  );
  assign any_wake = |(wake_pend & wake_arm);
  // acknowledged once the controller has left the low-power state
  assign wake_ack = (state == BCP_ST_NORM);

  assign ctrl_wr = reg_wr_in && (reg_addr_in == `BCP_ADDR_CTRL);
  assign int_rd = reg_rd_in && (reg_addr_in == `BCP_ADDR_INT_STAT);

  // sequencing; the hard reset pin overrides every state
  always_comb begin
    next_state = state;
    unique case (state)
      BCP_ST_HRST: begin
        if (por_done && hard_pin_n) begin
          next_state = BCP_ST_BOOT;
        end
      end
      BCP_ST_BOOT: begin
        if (loader_done_in) begin
          next_state = BCP_ST_NORM;
        end
      end
      BCP_ST_NORM: begin
        if (fw_suspend_req_in || (ctrl_wr && reg_wdata_in[`BCP_CTRL_SUSP_ON])) begin
          next_state = BCP_ST_SUSP_ON;
        end else if (ctrl_wr && reg_wdata_in[`BCP_CTRL_SUSP_OFF]) begin
          next_state = BCP_ST_SUSP_OFF;
        end else if (ctrl_wr && reg_wdata_in[`BCP_CTRL_STANDBY]) begin
          next_state = BCP_ST_STBY;
        end else if (ctrl_wr && reg_wdata_in[`BCP_CTRL_PDOWN]) begin
          next_state = BCP_ST_PDOWN;
        end
      end
      BCP_ST_SUSP_ON, BCP_ST_SUSP_OFF, BCP_ST_STBY: begin
        if (any_wake) begin
          next_state = BCP_ST_NORM;
        end
      end
      BCP_ST_PDOWN: begin
        next_state = BCP_ST_PDOWN; // only the reset pin leaves
      end
      default: begin
        next_state = BCP_ST_HRST;
      end
    endcase
    if (!hard_pin_n) begin
      next_state = BCP_ST_HRST;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= BCP_ST_HRST;
    end else begin
      state <= next_state;
    end
  end

  // straps latched on the way into boot so a late wiggle cannot move them
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      boot_src <= BCP_BOOT_USB;
      strap_bad <= 1'b0;
      ref_sel_out <= BCP_REF_XTAL_19M2;
      fallback_ev <= 1'b0;
    end else begin
      fallback_ev <= 1'b0;
      if (state == BCP_ST_HRST && next_state == BCP_ST_BOOT) begin
        ref_sel_out <= fsel_s;
        strap_bad <= 1'b0;
        if (!boot_flt_s[2] && !boot_lvl_s[2] && boot_flt_s[1]
            && !boot_flt_s[0] && boot_lvl_s[0]) begin
          boot_src <= BCP_BOOT_FLASH;
        end else begin
          boot_src <= BCP_BOOT_USB;
          // unlisted patterns boot from usb and raise a flag
          strap_bad <= !(boot_flt_s[2] && boot_flt_s[1:0] == 2'h0
                         && boot_lvl_s[1:0] == 2'h3);
        end
      end else if (state == BCP_ST_BOOT && loader_fail_in
                   && boot_src == BCP_BOOT_FLASH) begin
        boot_src <= BCP_BOOT_USB;
        fallback_ev <= 1'b1;
      end
    end
  end

  // reference decode steers the pll; patterns 001..011 are not listed
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pll_mult_out <= `BCP_PLL_MULT_19M2;
      ref_is_crystal_out <= 1'b1;
    end else begin
      ref_is_crystal_out <= !ref_sel_out[2];
      unique case (ref_sel_out)
        BCP_REF_CLK_26M: pll_mult_out <= `BCP_PLL_MULT_26M;
        BCP_REF_CLK_38M4: pll_mult_out <= `BCP_PLL_MULT_38M4;
        BCP_REF_CLK_52M: pll_mult_out <= `BCP_PLL_MULT_52M;
        default: pll_mult_out <= `BCP_PLL_MULT_19M2;
      endcase
    end
  end

  // clocks, pads and cpu controls follow the next state
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      io_tristate_out <= 1'b1;
      io_hold_out <= 1'b0;
      cpu_clk_en_out <= 1'b0;
      pll_en_out <= 1'b0;
      osc_en_out <= 1'b1;
      phy_en_out <= 1'b0;
      phy_u3_out <= 1'b0;
      boot_loader_run_out <= 1'b0;
      cpu_pc_reset_out <= 1'b1;
      power_state_out <= BCP_ST_HRST;
      boot_source_out <= BCP_BOOT_USB;
    end else begin
      power_state_out <= next_state;
      boot_source_out <= boot_src;
      io_tristate_out <= (next_state == BCP_ST_HRST);
      io_hold_out <= (next_state == BCP_ST_SUSP_ON)
                     || (next_state == BCP_ST_SUSP_OFF)
                     || (next_state == BCP_ST_STBY);
      cpu_clk_en_out <= (next_state == BCP_ST_BOOT)
                        || (next_state == BCP_ST_NORM);
      pll_en_out <= (next_state == BCP_ST_HRST) || (next_state == BCP_ST_BOOT)
                    || (next_state == BCP_ST_NORM);
      osc_en_out <= (next_state == BCP_ST_HRST) || (next_state == BCP_ST_BOOT)
                    || (next_state == BCP_ST_NORM);
      phy_en_out <= (next_state == BCP_ST_NORM)
                    || (next_state == BCP_ST_SUSP_ON);
      phy_u3_out <= (next_state == BCP_ST_SUSP_ON);
      boot_loader_run_out <= (next_state == BCP_ST_BOOT);
      // standby wake restarts the cpu, suspend wake keeps its place
      cpu_pc_reset_out <= (next_state == BCP_ST_HRST)
                          || (state == BCP_ST_STBY && next_state == BCP_ST_NORM);
    end
  end

  // sticky events; a set in the same cycle as the read survives
  always_comb begin
    int_set = '0;
    int_set[`BCP_INT_BOOT_DONE] = (state == BCP_ST_BOOT) && (next_state == BCP_ST_NORM);
    int_set[`BCP_INT_FALLBACK] = fallback_ev;
    int_set[`BCP_INT_WAKE] = any_wake && (next_state == BCP_ST_NORM);
    int_set[`BCP_INT_STRAP_ERR] = (state == BCP_ST_BOOT) && strap_bad;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      int_stat <= '0;
    end else begin
      int_stat <= (int_rd ? '0 : int_stat) | int_set;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      int_mask <= `BCP_INT_MASK_RST;
    end else if (reg_wr_in && reg_addr_in == `BCP_ADDR_INT_MASK) begin
      int_mask <= reg_wdata_in[`BCP_INT_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(((int_rd ? '0 : int_stat) | int_set) & int_mask);
    end
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (!reg_rd_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else begin
      unique case (reg_addr_in)
        `BCP_ADDR_STATUS: begin
          reg_rdata_out <= {18'h0_0000, strap_bad, boot_src, ref_sel_out,
                            1'b0, state};
        end
        `BCP_ADDR_INT_STAT: reg_rdata_out <= {28'h000_0000, int_stat};
        `BCP_ADDR_INT_MASK: reg_rdata_out <= {28'h000_0000, int_mask};
        default: reg_rdata_out <= 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n);

  sequence s_pin_low;
    !hard_pin_n;
  endsequence
  sequence s_l1_wake;
    state == BCP_ST_SUSP_ON && any_wake;
  endsequence

  a_reset_tristate: assert property (s_pin_low |=> io_tristate_out)
    else $error("io not tristated during hard reset");
  a_boot_after_reset: assert property (state == BCP_ST_HRST && next_state == BCP_ST_BOOT
    |=> boot_loader_run_out && state == BCP_ST_BOOT)
    else $error("loader not started after reset");
  a_flash_fallback: assert property (state == BCP_ST_BOOT && loader_fail_in
    && boot_src == BCP_BOOT_FLASH && hard_pin_n |=> boot_src == BCP_BOOT_USB ##1
    boot_source_out == BCP_BOOT_USB)
    else $error("no usb fallback after flash failure");
  a_por_hold: assert property (!por_done |-> state == BCP_ST_HRST)
    else $error("left reset before power-on hold");
  a_pll_mult: assert property (ref_sel_out == BCP_REF_CLK_52M |=>
    pll_mult_out == `BCP_PLL_MULT_52M)
    else $error("pll multiplier does not follow reference");
  a_crystal_flag: assert property ($changed(ref_sel_out) |=>
    ref_is_crystal_out == !$past(ref_sel_out[2]))
    else $error("crystal flag wrong");
  a_normal_clocks: assert property (state == BCP_ST_NORM |-> cpu_clk_en_out && pll_en_out)
    else $error("normal mode clocks off");
  a_l1_clocks: assert property (state == BCP_ST_SUSP_ON |-> phy_en_out && phy_u3_out
    && !cpu_clk_en_out && !pll_en_out && io_hold_out)
    else $error("suspend clocking or io hold wrong");
  a_l1_entry: assert property (state == BCP_ST_NORM && fw_suspend_req_in && hard_pin_n
    |=> state == BCP_ST_SUSP_ON)
    else $error("firmware suspend request ignored");
  a_l1_wake_pc: assert property (s_l1_wake and hard_pin_n |=> state == BCP_ST_NORM
    && !cpu_pc_reset_out)
    else $error("suspend wake wrong");
  a_stby_restart: assert property (state == BCP_ST_STBY && any_wake && hard_pin_n
    |=> cpu_pc_reset_out ##1 !cpu_pc_reset_out)
    else $error("standby wake did not restart cpu");
  a_wake_held: assert property (state == BCP_ST_STBY && wake_pend[`BCP_WK_VBUS]
    && hard_pin_n |=> state == BCP_ST_NORM)
    else $error("latched wake lost");
  a_state_codes: assert property (state inside {BCP_ST_HRST, BCP_ST_BOOT, BCP_ST_NORM,
    BCP_ST_SUSP_ON, BCP_ST_SUSP_OFF, BCP_ST_STBY, BCP_ST_PDOWN})
    else $error("illegal power state");
  a_boot_strap: assert property (state == BCP_ST_HRST && next_state == BCP_ST_BOOT
    && boot_flt_s == 3'h4 && boot_lvl_s[1:0] == 2'h3 |=> boot_src == BCP_BOOT_USB)
    else $error("usb boot strap not decoded");
endmodule

// ---- bcp_pkg.sv ----
package bcp_pkg;
  // one-hot power/sequence state
  typedef enum logic [6:0] {
    BCP_ST_HRST = 7'h01,
    BCP_ST_BOOT = 7'h02,
    BCP_ST_NORM = 7'h04,
    BCP_ST_SUSP_ON = 7'h08,
    BCP_ST_SUSP_OFF = 7'h10,
    BCP_ST_STBY = 7'h20,
    BCP_ST_PDOWN = 7'h40
  } bcp_pstate_t;
  typedef enum logic [1:0] {
    BCP_BOOT_USB = 2'h1,
    BCP_BOOT_FLASH = 2'h2
  } bcp_boot_src_t;
  typedef enum logic [2:0] {
    BCP_REF_XTAL_19M2 = 3'h0,
    BCP_REF_CLK_19M2 = 3'h4,
    BCP_REF_CLK_26M = 3'h5,
    BCP_REF_CLK_38M4 = 3'h6,
    BCP_REF_CLK_52M = 3'h7
  } bcp_ref_sel_t;
endpackage

// ---- bcp_sync.sv ----
`timescale 1ns/1ps
// two-stage synchroniser for pin levels
module bcp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // meta feeds only the second stage
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// ---- bcp_wake_host.sv ----
`timescale 1ns/1ps
// far side of the wake logic: usb data lines, id pin, receive pair,
// bus power and control line zero, each driven only when told to
module bcp_wake_host (
  input wire logic clk_in,
  output logic dp_out,
  output logic dm_out,
  output logic id_out,
  output logic superspeed_receive_pair_out,
  output logic vbus_out,
  output logic ctl0_out
);
  // dp idles high as on an idle full-speed bus, the rest low
  logic [5:0] lines = 6'h01;

  assign {ctl0_out, vbus_out, superspeed_receive_pair_out, id_out, dm_out, dp_out} = lines;

  // data and id lines change level and stay there; resume, bus power and
  // control line zero give a short high pulse, so a late fall never
  // lands while the sources are armed
  task automatic wake(input int idx);
    @(posedge clk_in);
    lines[idx] <= ~lines[idx];
    if (idx > 2) begin
      repeat (3) @(posedge clk_in);
      lines[idx] <= 1'b0;
    end
  endtask
endmodule

// ---- bcp_wake_latch.sv ----
`timescale 1ns/1ps
// wake event latches: reference level caught when armed, then any
// change (or a rise) sets a sticky request held until ack
module bcp_wake_latch #(
  parameter int WIDTH = 6,
  parameter logic [WIDTH-1:0] ANY_CHANGE = '0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] level_in,
  input wire logic [WIDTH-1:0] arm_in,
  input wire logic ack_in,
  output logic [WIDTH-1:0] pend_out
);
  logic [WIDTH-1:0] ref_lvl;
  logic [WIDTH-1:0] armed_q;
  logic [WIDTH-1:0] hit;

  // a change is only judged once the reference level is held
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (ANY_CHANGE[i]) begin
        hit[i] = armed_q[i] && arm_in[i] && (level_in[i] != ref_lvl[i]);
      end else begin
        hit[i] = armed_q[i] && arm_in[i] && level_in[i] && !ref_lvl[i];
      end
    end
  end

  // reference capture on arming
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ref_lvl <= '0;
      armed_q <= '0;
    end else begin
      armed_q <= arm_in;
      for (int i = 0; i < WIDTH; i++) begin
        if (arm_in[i] && !armed_q[i]) begin
          ref_lvl[i] <= level_in[i];
        end
      end
    end
  end

  // sticky request, a new hit wins over the acknowledge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend_out <= '0;
    end else begin
      pend_out <= (pend_out & ~{WIDTH{ack_in}}) | hit;
    end
  end
endmodule

// ---- tb_boot_clock_power_mode_ctrl.sv ----
`timescale 1ns/1ps
`include "bcp_cfg.svh"
module tb_boot_clock_power_mode_ctrl import bcp_pkg::*;;
  typedef struct packed {
    logic [2:0] fsel;
    logic [2:0] lvl;
    logic [2:0] flt;
    logic crys;
    logic [7:0] mult;
    logic [1:0] boot;
  } bcp_row_t;
  // strap inputs beside the clock choice, multiplier and boot source they give
  localparam bcp_row_t ROWS [6] = '{
    '{3'h0, 3'h3, 3'h4, 1'h1, 8'h14, 2'h1}, '{3'h4, 3'h1, 3'h2, 1'h0, 8'h14, 2'h2},
    '{3'h5, 3'h3, 3'h4, 1'h0, 8'h0F, 2'h1}, '{3'h6, 3'h1, 3'h2, 1'h0, 8'h0A, 2'h2},
    '{3'h7, 3'h3, 3'h4, 1'h0, 8'h08, 2'h1}, '{3'h4, 3'h0, 3'h0, 1'h0, 8'h14, 2'h1}};
  logic clk, rst_n, hard_n, ld_done, ld_fail, fw_req, wr, rd;
  logic [2:0] fsel, lvl, flt, ref_sel;
  logic [7:0] addr, mult;
  logic [31:0] wdata, rdata, d;
  logic irq, crys, run, tri_o, hold, cpu_en, pll_en, osc_en, phy_en, phy_u3, pc_rst;
  logic dp, dm, id, superspeed_receive_pair, vbus, ctl0;
  logic [1:0] boot;
  logic [6:0] state;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;

  bcp_wake_host host (.clk_in(clk), .dp_out(dp), .dm_out(dm), .id_out(id),
    .superspeed_receive_pair_out(superspeed_receive_pair), .vbus_out(vbus), .ctl0_out(ctl0));

  bcp_ctrl #(.POR_CYCLES(20)) dut (.ref_clk_in(clk), .resetn_in(rst_n),
    .hard_resetn_pin_in(hard_n), .ref_freq_select_straps_in(fsel),
    .boot_source_straps_in(lvl), .boot_source_float_in(flt), .loader_done_in(ld_done),
    .loader_fail_in(ld_fail), .fw_suspend_req_in(fw_req), .dp_in(dp), .dm_in(dm),
    .id_detect_pin_in(id), .superspeed_receive_pair_resume_in(superspeed_receive_pair), .vbus_detect_in(vbus),
    .parallel_control_line_zero_in(ctl0), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .irq_out(irq),
    .ref_sel_out(ref_sel), .ref_is_crystal_out(crys), .pll_mult_out(mult),
    .boot_source_out(boot), .boot_loader_run_out(run), .io_tristate_out(tri_o),
    .io_hold_out(hold), .cpu_clk_en_out(cpu_en), .pll_en_out(pll_en), .osc_en_out(osc_en),
    .phy_en_out(phy_en), .phy_u3_out(phy_u3), .cpu_pc_reset_out(pc_rst),
    .power_state_out(state));

  always #5 clk = ~clk;

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // a hang must still reach the verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      $display("ERROR at %0t: run took too long", $time);
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  // bounded wait, the caller compares the state afterwards
  task automatic wait_state(input logic [6:0] s, input int lim);
    for (int n = 0; n < lim && state !== s; n++) begin
      @(posedge clk);
      #1;
    end
  endtask

  task automatic do_boot(input bcp_row_t r);
    @(posedge clk);
    hard_n <= 1'b0;
    fsel <= r.fsel;
    lvl <= r.lvl;
    flt <= r.flt;
    repeat (4) @(posedge clk);
    #1;
    chk(tri_o, 1'b1, "io tristate");
    chk(state, BCP_ST_HRST, "hard reset state");
    @(posedge clk);
    hard_n <= 1'b1;
    wait_state(BCP_ST_BOOT, 60);
    @(posedge clk);
    #1;
    chk(run, 1'b1, "loader run");
    chk(ref_sel, r.fsel, "ref code");
    chk(crys, r.crys, "crystal");
    chk(mult, r.mult, "pll mult");
    chk(boot, r.boot, "boot source");
  endtask

  initial begin
    clk = 0;
    rst_n = 0;
    hard_n = 1;
    {ld_done, ld_fail, fw_req, wr, rd} = '0;
    fsel = 3'h0;
    lvl = 3'h3;
    flt = 3'h4;
    addr = 8'h00;
    wdata = 32'h0;
    // held well short of the real power-on time, the count is shortened too
    repeat (2) @(posedge clk);
    #1;
    chk(tri_o, 1'b1, "reset tristate");
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk(state, BCP_ST_HRST, "power-on hold");
    for (int i = 0; i < 6; i++) begin
      do_boot(ROWS[i]);
      $display("strap row %0d done", i);
    end
    // flash boot fails: source falls back to usb, masked flag keeps irq low
    do_boot(ROWS[1]);
    reg_rd(`BCP_ADDR_INT_STAT, d);
    @(posedge clk);
    ld_fail <= 1'b1;
    @(posedge clk);
    ld_fail <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(boot, BCP_BOOT_USB, "fallback source");
    chk(irq, 1'b0, "masked irq");
    reg_rd(`BCP_ADDR_INT_STAT, d);
    chk(d[`BCP_INT_FALLBACK], 1'b1, "fallback flag");
    reg_rd(8'h10, d);
    chk(d, 32'h0, "unmapped read");
    @(posedge clk);
    ld_done <= 1'b1;
    @(posedge clk);
    ld_done <= 1'b0;
    wait_state(BCP_ST_NORM, 4);
    chk({cpu_en, pll_en, run}, 3'h6, "normal clocks");
    reg_rd(`BCP_ADDR_STATUS, d);
    chk(d, 32'h0000_0C04, "status after fallback");
    $display("boot and fallback done");
    reg_wr(`BCP_ADDR_INT_MASK, 32'h4);
    // each wake source in turn; 0-3 from suspend, 4-5 from standby
    for (int i = 0; i < 6; i++) begin
      if (i == 0 || i == 2) begin
        @(posedge clk);
        fw_req <= 1'b1;
        @(posedge clk);
        fw_req <= 1'b0;
      end else begin
        reg_wr(`BCP_ADDR_CTRL, (i < 4) ? 32'h1 : 32'h4);
      end
      wait_state((i < 4) ? BCP_ST_SUSP_ON : BCP_ST_STBY, 4);
      chk(state, (i < 4) ? BCP_ST_SUSP_ON : BCP_ST_STBY, "low power entry");
      if (i < 4) begin
        chk({phy_en, phy_u3, cpu_en, pll_en, hold}, 5'h19, "suspend outputs");
        reg_wr(`BCP_ADDR_CTRL, 32'h4);
        #1;
        chk(state, BCP_ST_SUSP_ON, "request outside normal");
      end else begin
        chk({cpu_en, pll_en, osc_en}, 3'h0, "standby clocks");
      end
      host.wake(i);
      wait_state(BCP_ST_NORM, 10);
      chk(state, BCP_ST_NORM, "wake exit");
      chk(pc_rst, (i > 3), "pc reset on wake");
      @(posedge clk);
      #1;
      chk(irq, 1'b1, "wake irq");
      reg_rd(`BCP_ADDR_INT_STAT, d);
      chk(d[`BCP_INT_WAKE], 1'b1, "wake flag");
      @(posedge clk);
      #1;
      chk(irq, 1'b0, "irq after read");
      $display("wake source %0d done", i);
    end
    // suspend with phy off, then power-down that only the reset pin leaves
    reg_wr(`BCP_ADDR_CTRL, 32'h2);
    wait_state(BCP_ST_SUSP_OFF, 4);
    chk({state, phy_en, hold}, {BCP_ST_SUSP_OFF, 2'h1}, "phy off suspend");
    host.wake(4);
    wait_state(BCP_ST_NORM, 10);
    chk(state, BCP_ST_NORM, "phy off wake");
    reg_wr(`BCP_ADDR_CTRL, 32'h8);
    host.wake(5);
    repeat (6) @(posedge clk);
    #1;
    chk(state, BCP_ST_PDOWN, "power-down holds");
    do_boot(ROWS[0]);
    $display("phy off and power-down done");
    give_verdict();
  end
endmodule
